// ==== core/bdmf_core.sv ====
// Banked data memory, indirect addressing, bank selector, program counter low
// byte, table registers and the flag register of an 8-bit controller core.
// Assumes the core drives requests synchronously to clk_in, one per cycle.
`timescale 1ns/1ps

module bdmf_core (
   // Clock and power-up reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // Core data access
   input wire bdmf_pkg::bdmf_acc_req_type acc_req_in,
   output logic [7:0] rdata_out,
   output logic rvalid_out,
   // Flag update from the arithmetic unit
   input wire bdmf_pkg::bdmf_alu_req_type alu_req_in,
   // System events
   input wire bdmf_pkg::bdmf_sys_evt_type sys_evt_in,
   // Table read
   input wire bdmf_pkg::bdmf_tbl_req_type tbl_req_in,
   output logic [7:0] tbl_ptr_low_out,
   output logic [7:0] tbl_ptr_high_out,
   // Program counter low byte
   input wire logic [7:0] pc_low_in,
   output logic pc_jump_out,
   output logic [7:0] pc_low_out,
   output logic pc_dummy_out,
   // Eeprom control register, kept outside this block
   input wire logic [7:0] ee_ctrl_rdata_in,
   output logic ee_ctrl_wr_out,
   output logic [7:0] ee_ctrl_wdata_out,
   // Status for the rest of the core
   output logic [7:0] flags_out,
   output logic bank_out
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   bdmf_pkg::bdmf_state_type s_q;
   bdmf_pkg::bdmf_state_type s_d;
   logic [7:0] gp_mem [0:bdmf_pkg::GP_WORDS-1];

   logic ind_acc;
   logic null_acc;
   logic acc_bank;
   logic [7:0] acc_addr;
   logic [7:0] acc_val;
   logic acc_wen;
   logic [7:0] acc_wval;
   logic wen;
   logic wbank;
   logic [7:0] waddr;
   logic [7:0] wval;
   logic mem_we;
   logic [6:0] mem_idx;
   logic [8:0] sum9;
   logic [4:0] sum5;
   logic [7:0] sum7;
   logic [7:0] opb;
   logic cin;

   // ---------------------------------------------------------------
   // Read decode
   // ---------------------------------------------------------------
   // Special registers decode the same in both banks; only 40h and up
   // look at the bank.
   function automatic logic [7:0] read_loc(input logic bank, input logic [7:0] addr);
      logic [7:0] v;
      v = 8'h00;
      if (addr < bdmf_pkg::ADDR_GP_BASE) begin
         case (addr)
            bdmf_pkg::ADDR_PTR0: v = s_q.ptr0;
            bdmf_pkg::ADDR_PTR1: v = s_q.ptr1;
            bdmf_pkg::ADDR_BANK: v = {7'h00, s_q.bank};
            bdmf_pkg::ADDR_PCL: v = pc_low_in;
            bdmf_pkg::ADDR_TBLP: v = s_q.tblp;
            bdmf_pkg::ADDR_TBHP: v = s_q.tbhp;
            bdmf_pkg::ADDR_TABLE_HIGH_BYTE: v = s_q.table_high_byte;
            bdmf_pkg::ADDR_FLAGS: v = s_q.flags;
            default: v = 8'h00;
         endcase
      end else if (addr < bdmf_pkg::ADDR_LIMIT) begin
         // eeprom control answers only in bank 1
         if (bank && addr == bdmf_pkg::ADDR_EEPROM_CONTROL_REG) begin
            v = ee_ctrl_rdata_in;
         end else begin
            v = gp_mem[{bank, addr[5:0]}];
         end
      end
      return v;
   endfunction

   // ---------------------------------------------------------------
   // Address resolution for the core access
   // ---------------------------------------------------------------
   always_comb begin
      ind_acc = 1'b0;
      acc_bank = 1'b0;
      acc_addr = acc_req_in.addr;
      if (acc_req_in.addr == bdmf_pkg::ADDR_IND0) begin
         ind_acc = 1'b1;
         // port zero is fixed to bank 0
         acc_bank = 1'b0;
         acc_addr = s_q.ptr0;
      end else if (acc_req_in.addr == bdmf_pkg::ADDR_IND1) begin
         ind_acc = 1'b1;
         acc_bank = s_q.bank;
         acc_addr = s_q.ptr1;
      end else begin
         acc_bank = 1'b0;
      end
      // pointer aimed at a port is a null access
      null_acc = ind_acc && (acc_addr == bdmf_pkg::ADDR_IND0 ||
                             acc_addr == bdmf_pkg::ADDR_IND1);
      acc_val = null_acc ? 8'h00 : read_loc(acc_bank, acc_addr);
      acc_wval = acc_req_in.wdata;
      if (acc_req_in.bset) begin
         acc_wval = acc_val | (8'h01 << acc_req_in.bit_idx);
      end else if (acc_req_in.bclr) begin
         acc_wval = acc_val & ~(8'h01 << acc_req_in.bit_idx);
      end
      acc_wen = (acc_req_in.wr || acc_req_in.bset || acc_req_in.bclr) && !null_acc;
   end

   // ---------------------------------------------------------------
   // Write port select
   // ---------------------------------------------------------------
   // A table read owns the write port in its cycle; the core never
   // issues a data write in the same cycle as a table read.
   always_comb begin
      if (tbl_req_in.valid) begin
         // low byte to operand, direct so bank 0
         wen = 1'b1;
         wbank = 1'b0;
         waddr = tbl_req_in.dest;
         wval = tbl_req_in.word[7:0];
      end else begin
         wen = acc_wen;
         wbank = acc_bank;
         waddr = acc_addr;
         wval = acc_wval;
      end
      mem_we = wen && waddr >= bdmf_pkg::ADDR_GP_BASE && waddr < bdmf_pkg::ADDR_LIMIT &&
               !(wbank && waddr == bdmf_pkg::ADDR_EEPROM_CONTROL_REG);
      mem_idx = {wbank, waddr[5:0]};
   end

   // ---------------------------------------------------------------
   // Flag arithmetic
   // ---------------------------------------------------------------
   // Subtraction runs as a + ~b + 1, so carry out means no borrow.
   always_comb begin
      opb = (alu_req_in.op == bdmf_pkg::BDMF_OP_SUB) ? ~alu_req_in.b : alu_req_in.b;
      cin = (alu_req_in.op == bdmf_pkg::BDMF_OP_SUB);
      sum9 = {1'b0, alu_req_in.a} + {1'b0, opb} + {8'h00, cin};
      sum5 = {1'b0, alu_req_in.a[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
      sum7 = {1'b0, alu_req_in.a[6:0]} + {1'b0, opb[6:0]} + {7'h00, cin};
   end

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.rvalid = acc_req_in.rd;
      s_d.rdata = acc_req_in.rd ? acc_val : 8'h00;
      s_d.pc_jump = 1'b0;
      s_d.pc_dummy = s_q.pc_jump;
      s_d.ee_wr = 1'b0;

      // Register writes; bits with no storage are dropped
      if (wen) begin
         case (waddr)
            bdmf_pkg::ADDR_PTR0: s_d.ptr0 = wval;
            bdmf_pkg::ADDR_PTR1: s_d.ptr1 = wval;
            bdmf_pkg::ADDR_BANK: s_d.bank = wval[bdmf_pkg::BANK_BIT];
            bdmf_pkg::ADDR_TBLP: s_d.tblp = wval;
            bdmf_pkg::ADDR_TBHP: s_d.tbhp = wval;
            bdmf_pkg::ADDR_FLAGS: begin
               s_d.flags = (s_q.flags & ~bdmf_pkg::FLAGS_SW_MASK) |
                           (wval & bdmf_pkg::FLAGS_SW_MASK);
            end
            bdmf_pkg::ADDR_PCL: begin
               s_d.pc_jump = 1'b1;
               s_d.pc_low = wval;
            end
            bdmf_pkg::ADDR_EEPROM_CONTROL_REG: begin
               if (wbank) begin
                  s_d.ee_wr = 1'b1;
                  s_d.ee_wdata = wval;
               end
            end
            default: ;
         endcase
      end

      if (tbl_req_in.valid) begin
         s_d.table_high_byte = tbl_req_in.word[15:8];
      end

      // Arithmetic unit result wins over a software flag write
      if (alu_req_in.valid) begin
         case (alu_req_in.op)
            bdmf_pkg::BDMF_OP_ADD, bdmf_pkg::BDMF_OP_SUB: begin
               s_d.flags[bdmf_pkg::FLAG_C] = sum9[8];
               s_d.flags[bdmf_pkg::FLAG_AC] = sum5[4];
               s_d.flags[bdmf_pkg::FLAG_Z] = (sum9[7:0] == 8'h00);
               // carry in and out of bit 7 differ
               s_d.flags[bdmf_pkg::FLAG_OV] = sum7[7] ^ sum9[8];
            end
            bdmf_pkg::BDMF_OP_LOGIC: begin
               s_d.flags[bdmf_pkg::FLAG_Z] = (alu_req_in.res == 8'h00);
            end
            bdmf_pkg::BDMF_OP_ROTC: begin
               s_d.flags[bdmf_pkg::FLAG_C] = alu_req_in.rot_left ? alu_req_in.a[7] :
                                                                   alu_req_in.a[0];
            end
            default: ;
         endcase
      end

      // Clears first so that a same-cycle set wins
      // power-down and time-out flag events
      if (sys_evt_in.wdt_clear) begin
         s_d.flags[bdmf_pkg::FLAG_PDF] = 1'b0;
      end
      if (sys_evt_in.halt) begin
         s_d.flags[bdmf_pkg::FLAG_PDF] = 1'b1;
      end
      if (sys_evt_in.wdt_clear || sys_evt_in.halt) begin
         s_d.flags[bdmf_pkg::FLAG_TO] = 1'b0;
      end
      if (sys_evt_in.wdt_timeout) begin
         s_d.flags[bdmf_pkg::FLAG_TO] = 1'b1;
      end
      // bits 7 and 6 always zero
      s_d.flags[7:6] = 2'b00;

      // system reset, sleep watchdog reset keeps bank
      if (sys_evt_in.sys_reset && !sys_evt_in.wdt_sleep_reset) begin
         s_d.bank = bdmf_pkg::BANK_RESET;
      end
   end

   // ---------------------------------------------------------------
   // State registers
   // ---------------------------------------------------------------
   // Power-up clears everything, so both status flags start clear.
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ---------------------------------------------------------------
   // General-purpose storage
   // ---------------------------------------------------------------
   // No reset: contents are undefined after power-up, as for any RAM.
   always_ff @(posedge clk_in) begin
      if (mem_we) begin
         gp_mem[mem_idx] <= wval;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   // no flag save path exists; software preserves the flags
   assign rdata_out = s_q.rdata;
   assign rvalid_out = s_q.rvalid;
   assign tbl_ptr_low_out = s_q.tblp;
   assign tbl_ptr_high_out = s_q.tbhp;
   assign pc_jump_out = s_q.pc_jump;
   assign pc_low_out = s_q.pc_low;
   assign pc_dummy_out = s_q.pc_dummy;
   assign ee_ctrl_wr_out = s_q.ee_wr;
   assign ee_ctrl_wdata_out = s_q.ee_wdata;
   assign flags_out = s_q.flags;
   assign bank_out = s_q.bank;

endmodule // bdmf_core

// ==== pkg/bdmf_pkg.sv ====
// Constants, field layouts and carrier types of the banked data memory block.
// Assumes a core that issues at most one data access per clock.
package bdmf_pkg;

   // ---------------------------------------------------------------
   // Data memory map (byte addresses within one bank)
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_IND0 = 8'h00;
   localparam logic [7:0] ADDR_PTR0 = 8'h01;
   localparam logic [7:0] ADDR_IND1 = 8'h02;
   localparam logic [7:0] ADDR_PTR1 = 8'h03;
   localparam logic [7:0] ADDR_BANK = 8'h04;
   localparam logic [7:0] ADDR_PCL = 8'h06;
   localparam logic [7:0] ADDR_TBLP = 8'h07;
   localparam logic [7:0] ADDR_TABLE_HIGH_BYTE = 8'h08;
   localparam logic [7:0] ADDR_TBHP = 8'h09;
   localparam logic [7:0] ADDR_FLAGS = 8'h0a;
   localparam logic [7:0] ADDR_EEPROM_CONTROL_REG = 8'h40;
   localparam logic [7:0] ADDR_GP_BASE = 8'h40;
   localparam logic [7:0] ADDR_LIMIT = 8'h80;
   localparam int GP_WORDS = 128;

   // ---------------------------------------------------------------
   // Field positions, masks and reset values
   // ---------------------------------------------------------------
   localparam int BANK_BIT = 0;
   localparam logic [7:0] BANK_MASK = 8'h01;
   localparam int FLAG_C = 0;
   localparam int FLAG_AC = 1;
   localparam int FLAG_Z = 2;
   localparam int FLAG_OV = 3;
   localparam int FLAG_PDF = 4;
   localparam int FLAG_TO = 5;
   localparam logic [7:0] FLAGS_SW_MASK = 8'h0f;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic BANK_RESET = 1'b0;

   // ---------------------------------------------------------------
   // Carrier types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      BDMF_OP_ADD,
      BDMF_OP_SUB,
      BDMF_OP_LOGIC,
      BDMF_OP_ROTC
   } bdmf_alu_op_type;

   typedef struct packed {
      logic rd;
      logic wr;
      logic bset;
      logic bclr;
      logic [2:0] bit_idx;
      logic [7:0] addr;
      logic [7:0] wdata;
   } bdmf_acc_req_type;

   typedef struct packed {
      logic valid;
      bdmf_alu_op_type op;
      logic [7:0] a;
      logic [7:0] b;
      logic [7:0] res;
      logic rot_left;
   } bdmf_alu_req_type;

   typedef struct packed {
      logic halt;
      logic wdt_clear;
      logic wdt_timeout;
      logic sys_reset;
      logic wdt_sleep_reset;
   } bdmf_sys_evt_type;

   typedef struct packed {
      logic valid;
      logic [15:0] word;
      logic [7:0] dest;
   } bdmf_tbl_req_type;

   typedef struct packed {
      logic [7:0] ptr0;
      logic [7:0] ptr1;
      logic bank;
      logic [7:0] tblp;
      logic [7:0] tbhp;
      logic [7:0] table_high_byte;
      logic [7:0] flags;
      logic [7:0] rdata;
      logic rvalid;
      logic pc_jump;
      logic pc_dummy;
      logic [7:0] pc_low;
      logic ee_wr;
      logic [7:0] ee_wdata;
   } bdmf_state_type;

endpackage

// ==== test/bdmf_core_props.sv ====
// Checker for the banked data memory block.
// Sees only the top ports; bound to every bdmf_core below.
`timescale 1ns/1ps
module bdmf_core_props (
   // Clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // Requests
   input wire bdmf_pkg::bdmf_acc_req_type acc_req_in,
   input wire bdmf_pkg::bdmf_alu_req_type alu_req_in,
   input wire bdmf_pkg::bdmf_sys_evt_type sys_evt_in,
   // Answers
   input wire logic [7:0] rdata_out,
   input wire logic rvalid_out,
   input wire logic pc_jump_out,
   input wire logic [7:0] pc_low_out,
   input wire logic pc_dummy_out,
   input wire logic [7:0] flags_out,
   input wire logic bank_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   // Nine-bit sum so carry out and zero come from one place
   logic [8:0] sum;
   assign sum = {1'b0, alu_req_in.a} + {1'b0, alu_req_in.b};
   read_lat_a: assert property (rvalid_out == $past(acc_req_in.rd))
      else $error("read answer not one cycle after request");
   bank_read_a: assert property (acc_req_in.rd && acc_req_in.addr == bdmf_pkg::ADDR_BANK
      |=> rdata_out == {7'h00, $past(bank_out)}) else $error("bank register read wrong");
   pc_walk_a: assert property (acc_req_in.wr && acc_req_in.addr == bdmf_pkg::ADDR_PCL
      |=> pc_jump_out && pc_low_out == $past(acc_req_in.wdata) ##1 pc_dummy_out)
      else $error("counter low write did not jump");
   flag_top_a: assert property (flags_out[7:6] == 2'b00)
      else $error("flag top bits not zero");
   halt_flags_a: assert property (sys_evt_in.halt && !sys_evt_in.wdt_timeout
      |=> flags_out[5:4] == 2'b01) else $error("halt flags wrong");
   tout_set_a: assert property (sys_evt_in.wdt_timeout |=> flags_out[5])
      else $error("timeout flag not set");
   sw_keep_a: assert property (acc_req_in.wr && acc_req_in.addr == bdmf_pkg::ADDR_FLAGS
      && !(sys_evt_in.halt || sys_evt_in.wdt_clear || sys_evt_in.wdt_timeout)
      |=> $stable(flags_out[5:4])) else $error("software changed system flags");
   bank_clr_a: assert property (sys_evt_in.sys_reset && !sys_evt_in.wdt_sleep_reset
      |=> !bank_out) else $error("reset kept bank one");
   add_flags_a: assert property (alu_req_in.valid && alu_req_in.op == bdmf_pkg::BDMF_OP_ADD
      |=> flags_out[2] == ($past(sum[7:0]) == 8'h00) && flags_out[0] == $past(sum[8]))
      else $error("add zero or carry wrong");
endmodule // bdmf_core_props

bind bdmf_core bdmf_core_props u_bdmf_core_props (.clk_in(clk_in), .nrst_in(nrst_in),
   .acc_req_in(acc_req_in), .alu_req_in(alu_req_in), .sys_evt_in(sys_evt_in),
   .rdata_out(rdata_out), .rvalid_out(rvalid_out), .pc_jump_out(pc_jump_out),
   .pc_low_out(pc_low_out), .pc_dummy_out(pc_dummy_out), .flags_out(flags_out),
   .bank_out(bank_out));

// ==== test/bdmf_core_model.sv ====
// Processor core model: issues one data access at a time to the block.
// Assumes the block answers one edge after the request is taken.
`timescale 1ns/1ps
module bdmf_core_model (
   // Clock
   input wire logic clk_in,
   // Data access
   output bdmf_pkg::bdmf_acc_req_type acc_req_out,
   input wire logic [7:0] rdata_in,
   input wire logic rvalid_in
);
   // ---------------------------------------------------------------
   // Access task
   // ---------------------------------------------------------------
   initial acc_req_out = '0;
   // Held over one rising edge; the idle gap keeps drives one per time step
   task automatic go(input logic [3:0] k, input logic [2:0] i, input logic [7:0] a,
                     input logic [7:0] d, output logic [7:0] q, output logic v);
      @(negedge clk_in);
      acc_req_out = {k, i, a, d};
      @(negedge clk_in);
      acc_req_out = '0;
      q = rdata_in;
      v = rvalid_in;
   endtask
endmodule // bdmf_core_model

// ==== test/tb_bdmf_core.sv ====
// Self-checking bench for the banked data memory block.
// Core model drives accesses; events and flag updates come from here.
`timescale 1ns/1ps
module tb_bdmf_core;
   // ---------------------------------------------------------------
   // Signals and instances
   // ---------------------------------------------------------------
   logic clk_in = 1'b0;
   logic nrst_in = 1'b0;
   bdmf_pkg::bdmf_acc_req_type acc;
   bdmf_pkg::bdmf_alu_req_type alu = '0;
   bdmf_pkg::bdmf_sys_evt_type sev = '0;
   bdmf_pkg::bdmf_tbl_req_type tbl = '0;
   logic [7:0] rdata, pc_low, ee_wdata, flags, q, tblp, tbhp;
   logic rvalid, pc_jump, pc_dummy, ee_wr, bank, v;
   int err_count = 0;
   int cmp_count = 0;
   always #50 clk_in = ~clk_in;
   bdmf_core u_bdmf_core (.clk_in(clk_in), .nrst_in(nrst_in), .acc_req_in(acc),
      .rdata_out(rdata), .rvalid_out(rvalid), .alu_req_in(alu), .sys_evt_in(sev),
      .tbl_req_in(tbl), .tbl_ptr_low_out(tblp), .tbl_ptr_high_out(tbhp), .pc_low_in(8'h12),
      .pc_jump_out(pc_jump), .pc_low_out(pc_low), .pc_dummy_out(pc_dummy),
      .ee_ctrl_rdata_in(8'h3c), .ee_ctrl_wr_out(ee_wr), .ee_ctrl_wdata_out(ee_wdata),
      .flags_out(flags), .bank_out(bank));
   bdmf_core_model u_bdmf_core_model (.clk_in(clk_in), .acc_req_out(acc),
      .rdata_in(rdata), .rvalid_in(rvalid));
   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      u_bdmf_core_model.go(4'h4, 3'h0, a, d, q, v);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      u_bdmf_core_model.go(4'h8, 3'h0, a, 8'h00, q, v);
      chk("rvalid", 8'h01, {7'h00, v});
      chk("rdata", e, q);
   endtask
   task automatic ev(input bdmf_pkg::bdmf_sys_evt_type e);
      @(negedge clk_in);
      sev = e;
      @(negedge clk_in);
      sev = '0;
   endtask
   // Flag update pulse; flags are judged once it has landed
   task automatic al(input bdmf_pkg::bdmf_alu_op_type o, input logic [7:0] a,
                     input logic [7:0] b, input logic [7:0] r, input logic rl,
                     input logic [7:0] e);
      @(negedge clk_in);
      alu = {1'b1, o, a, b, r, rl};
      @(negedge clk_in);
      alu = '0;
      chk("flags", e, flags);
   endtask
   task automatic give_verdict();
      if (err_count == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_bank();
      chk("flags", 8'h00, flags);
      rd(8'h04, 8'h00);
      wr(8'h04, 8'hff);
      rd(8'h04, 8'h01);
      ev(5'b00011);
      chk("bank", 8'h01, {7'h00, bank});
      ev(5'b00010);
      chk("bank", 8'h00, {7'h00, bank});
   endtask
   task automatic t_ind();
      wr(8'h04, 8'h01);
      wr(8'h01, 8'h45);
      wr(8'h00, 8'haa);
      rd(8'h45, 8'haa);
      wr(8'h03, 8'h45);
      wr(8'h02, 8'h55);
      rd(8'h02, 8'h55);
      rd(8'h45, 8'haa);
      wr(8'h04, 8'h00);
      rd(8'h02, 8'haa);
      wr(8'h03, 8'h00);
      wr(8'h02, 8'h77);
      rd(8'h02, 8'h00);
      rd(8'h01, 8'h45);
   endtask
   task automatic t_ee();
      wr(8'h04, 8'h01);
      wr(8'h03, 8'h40);
      wr(8'h02, 8'h5a);
      chk("ee_wr", 8'h01, {7'h00, ee_wr});
      chk("ee_wdata", 8'h5a, ee_wdata);
      rd(8'h02, 8'h3c);
      wr(8'h04, 8'h00);
      wr(8'h02, 8'h66);
      chk("ee_wr", 8'h00, {7'h00, ee_wr});
      rd(8'h40, 8'h66);
   endtask
   task automatic t_pcl();
      wr(8'h06, 8'h7e);
      chk("pc_jump", 8'h01, {7'h00, pc_jump});
      chk("pc_low", 8'h7e, pc_low);
      @(negedge clk_in);
      chk("pc_dummy", 8'h01, {7'h00, pc_dummy});
      rd(8'h06, 8'h12);
   endtask
   task automatic t_flags();
      wr(8'h0a, 8'hff);
      rd(8'h0a, 8'h0f);
      al(bdmf_pkg::BDMF_OP_ADD, 8'hff, 8'h01, 8'h00, 1'b0, 8'h07);
      al(bdmf_pkg::BDMF_OP_SUB, 8'h80, 8'h01, 8'h7f, 1'b0, 8'h09);
      al(bdmf_pkg::BDMF_OP_LOGIC, 8'h00, 8'h00, 8'h00, 1'b0, 8'h0d);
      al(bdmf_pkg::BDMF_OP_ROTC, 8'h00, 8'h00, 8'h00, 1'b1, 8'h0c);
      ev(5'b00100);
      chk("flags", 8'h2c, flags);
      ev(5'b10000);
      chk("flags", 8'h1c, flags);
      ev(5'b00100);
      wr(8'h0a, 8'h00);
      rd(8'h0a, 8'h30);
      u_bdmf_core_model.go(4'h1, 3'h5, 8'h0a, 8'h00, q, v);
      rd(8'h0a, 8'h30);
      ev(5'b01000);
      chk("flags", 8'h00, flags);
   endtask
   task automatic t_tbl();
      @(negedge clk_in);
      tbl = {1'b1, 16'habcd, 8'h50};
      @(negedge clk_in);
      tbl = '0;
      wr(8'h08, 8'h00);
      rd(8'h08, 8'hab);
      u_bdmf_core_model.go(4'h2, 3'h4, 8'h50, 8'h00, q, v);
      u_bdmf_core_model.go(4'h1, 3'h0, 8'h50, 8'h00, q, v);
      rd(8'h50, 8'hdc);
      wr(8'h07, 8'h3a);
      wr(8'h09, 8'h02);
      chk("tblp", 8'h3a, tblp);
      chk("tbhp", 8'h02, tbhp);
      rd(8'h07, 8'h3a);
      rd(8'h09, 8'h02);
   endtask
   // ---------------------------------------------------------------
   // Main sequence and hang guard
   // ---------------------------------------------------------------
   initial begin
      repeat (16) @(negedge clk_in);
      nrst_in = 1'b1;
      t_bank();
      t_ind();
      t_ee();
      t_pcl();
      t_flags();
      t_tbl();
      give_verdict();
   end
   // A stuck run counts as a mismatch
   initial begin
      repeat (5000) @(posedge clk_in);
      err_count++;
      give_verdict();
   end
endmodule // tb_bdmf_core
